// ===== vovr_regs.v
/*
 overvoltage limit and response command registers with range checks,
 status flags, alert, nonvolatile image and restart control.
 assumes a command decoder giving one-cycle write and read strobes.
*/
`timescale 1ns/1ps
`include "vovr_defs.vh"
module vovr_regs
#(
   parameter RISE_CYCLES = `VOVR_RISE_CYC
)
(
   input  wire        clk,
   input  wire        rst_n,
   input  wire        wr_en,
   input  wire [7:0]  wr_cmd,
   input  wire [15:0] wr_data,
   input  wire [7:0]  rd_cmd,
   output reg  [15:0] rd_data,
   input  wire [9:0]  scale_loop,
   input  wire [11:0] vout_command,
   input  wire        ov_fault_det,
   input  wire        ov_warn_det,
   input  wire        clear_faults,
   input  wire        store_all,
   input  wire        restore_all,
   input  wire        alert_mask,
   input  wire        run_cmd,
   output wire        alert_n,
   output reg  [7:0]  status_byte,
   output reg  [15:0] status_word,
   output reg  [7:0]  status_vout,
   output reg  [7:0]  status_cml,
   output wire        out_enable,
   output wire        soft_start,
   output reg  [11:0] nv_fault,
   output reg  [7:0]  nv_resp,
   output reg  [11:0] nv_warn,
   output reg  [6:0]  nv_cal
);
   reg  [11:0] fault_q;
   reg  [11:0] warn_q;
   reg         act_q;
   reg  [2:0]  retry_q;
   reg  [6:0]  cal_q;
   reg         bad;
   wire [21:0] fault_scaled;
   wire [21:0] warn_scaled;
   wire [11:0] warn_def;
   wire [11:0] fault_nv;
   wire        fault_wr;
   wire        warn_wr;
   wire        resp_wr;
   // check on the full word before update
   assign fault_scaled = wr_data[11:0] * scale_loop;
   assign warn_scaled  = wr_data[11:0] * scale_loop;
   assign fault_wr = wr_en && (wr_cmd == `VOVR_CMD_OV_FAULT);
   assign warn_wr  = wr_en && (wr_cmd == `VOVR_CMD_OV_WARN);
   assign resp_wr  = wr_en && (wr_cmd == `VOVR_CMD_OV_RESP);
   // low four bits dropped in nonvolatile image
   assign fault_nv = nv_fault & `VOVR_NV_FAULT_MASK;
   // default warn from stored fault limit
   assign warn_def = fault_nv - {4'h0, fault_nv[11:4]};
   always @*
   begin
      bad = 1'b0;
      // fault above warn and below scaled ceiling
      if (fault_wr)
         bad = (wr_data[15:12] != 4'h0) || (wr_data[11:0] <= warn_q)
               || (fault_scaled >= `VOVR_FAULT_MAX);
      if (warn_wr)
         bad = (wr_data[15:12] != 4'h0)
               || (warn_scaled <= `VOVR_WARN_MIN);
      // retry must be all zeros or all ones
      if (resp_wr)
         bad = (wr_data[5:3] != 3'h0) && (wr_data[5:3] != 3'h7);
   end
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fault_q <= `VOVR_FAULT_RST;
         warn_q  <= `VOVR_WARN_RST;
         act_q   <= 1'b1;
         retry_q <= 3'h7;
         cal_q   <= 7'h00;
         nv_fault <= `VOVR_FAULT_RST;
         nv_warn  <= `VOVR_WARN_RST;
         nv_resp  <= `VOVR_RESP_RST;
         nv_cal   <= 7'h00;
      end
      else
      begin
         if (fault_wr && !bad)
            fault_q <= wr_data[11:0];
         if (warn_wr && !bad)
            warn_q <= wr_data[11:0];
         if (resp_wr && !bad)
         begin
            act_q   <= wr_data[`VOVR_RESP_ACT];
            retry_q <= wr_data[`VOVR_RESP_RETRY_HI:`VOVR_RESP_RETRY_LO];
         end
         // only sign and low six bits stored
         if (wr_en && (wr_cmd == `VOVR_CMD_CAL_OFS))
            cal_q <= {wr_data[10], wr_data[5:0]};
         if (store_all)
         begin
            // low four bits never reach the image
            nv_fault <= fault_q & `VOVR_NV_FAULT_MASK;
            nv_warn  <= warn_q;
            // only bit five of retry kept
            nv_resp  <= {act_q, 1'b0, retry_q[2], 2'h0, `VOVR_RESP_DELAY};
            nv_cal   <= cal_q;
         end
         else if (restore_all)
         begin
            fault_q <= fault_nv;
            act_q   <= nv_resp[`VOVR_RESP_ACT];
            retry_q <= {3{nv_resp[`VOVR_RESP_RETRY_HI]}};
            cal_q   <= nv_cal;
            // fall back below fault when too low
            if (warn_def > vout_command)
               warn_q <= warn_def;
            else
               warn_q <= fault_nv - 12'h001;
         end
      end
   end
   // status flags: set wins over clear
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_byte <= 8'h00;
         status_word <= 16'h0000;
         status_vout <= 8'h00;
         status_cml  <= 8'h00;
      end
      else
      begin
         if (clear_faults)
         begin
            status_byte <= 8'h00;
            status_word <= 16'h0000;
            status_vout <= 8'h00;
            status_cml  <= 8'h00;
         end
         if (bad)
         begin
            status_byte[`VOVR_SB_CML] <= 1'b1;
            status_cml[`VOVR_SC_IVD]  <= 1'b1;
         end
         // fault sets its flags in three registers
         if (ov_fault_det)
         begin
            status_byte[`VOVR_SB_VOUT_OV] <= 1'b1;
            status_word[`VOVR_SW_VOUT]    <= 1'b1;
            status_vout[`VOVR_SV_OV_FAULT] <= 1'b1;
            if (act_q)
               status_byte[`VOVR_SB_OFF] <= 1'b1;
         end
         // warning sets its flags in three registers
         if (ov_warn_det)
         begin
            status_byte[`VOVR_SB_OTHER] <= 1'b1;
            status_word[`VOVR_SW_VOUT]  <= 1'b1;
            status_vout[`VOVR_SV_OV_WARN]  <= 1'b1;
         end
      end
   end
   // alert stays while a flag stands, unless masked
   assign alert_n = ~(!alert_mask && ((status_byte != 8'h00)
                    || (status_vout != 8'h00) || (status_cml != 8'h00)));
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rd_data <= 16'h0000;
      else
         case (rd_cmd)
            `VOVR_CMD_OV_FAULT: rd_data <= {4'h0, fault_q};
            `VOVR_CMD_OV_WARN:  rd_data <= {4'h0, warn_q};
            // fixed zero and fixed delay bits
            `VOVR_CMD_OV_RESP:
               rd_data <= {8'h00, act_q, 1'b0, retry_q, `VOVR_RESP_DELAY};
            `VOVR_CMD_CAL_OFS:
               rd_data <= {`VOVR_CAL_EXP, cal_q[6], {4{cal_q[6]}},
                           cal_q[5:0]};
            default: rd_data <= 16'h0000;
         endcase
   end
   vovr_restart u_restart
   (
      .clk           (clk),
      .rst_n         (rst_n),
      .ov_fault      (ov_fault_det),
      .action_sel    (act_q),
      .retry_setting (retry_q),
      .fault_clear   (clear_faults),
      .run_cmd       (run_cmd),
      .rise_cycles   (RISE_CYCLES[15:0]),
      .out_enable    (out_enable),
      .soft_start    (soft_start)
   );
endmodule

// ===== vovr_defs.vh
/*
 holds the command codes, field positions, reset values and limits of the
 overvoltage limit and response register bank.
 assumes a command decoder outside that delivers whole command words.
*/
`ifndef VOVR_DEFS_VH
`define VOVR_DEFS_VH
`define VOVR_CMD_CAL_OFS     8'h39
`define VOVR_CMD_OV_FAULT    8'h40
`define VOVR_CMD_OV_RESP     8'h41
`define VOVR_CMD_OV_WARN     8'h42
`define VOVR_CAL_EXP         5'h1C
`define VOVR_CAL_RST         16'hE000
`define VOVR_FAULT_RST       12'h290
`define VOVR_WARN_RST        12'h267
`define VOVR_RESP_RST        8'hBF
`define VOVR_RESP_ACT        7
`define VOVR_RESP_ZERO       6
`define VOVR_RESP_RETRY_HI   5
`define VOVR_RESP_RETRY_LO   3
`define VOVR_RESP_DELAY      3'h7
`define VOVR_FAULT_MAX       22'h00039A
`define VOVR_WARN_MIN        22'h00010D
`define VOVR_NV_FAULT_MASK   12'hFF0
`define VOVR_SB_OFF          6
`define VOVR_SB_VOUT_OV      5
`define VOVR_SB_CML          1
`define VOVR_SB_OTHER        0
`define VOVR_SW_VOUT         15
`define VOVR_SV_OV_FAULT     7
`define VOVR_SV_OV_WARN      6
`define VOVR_SC_IVD          6
`define VOVR_RISE_CYC        16'h0100
`endif

// ===== vovr_restart.v
/*
 restart sequencer for the overvoltage fault response.
 assumes fault and enable levels synchronous to clk.
*/
`timescale 1ns/1ps
`include "vovr_defs.vh"
module vovr_restart
(
   input  wire        clk,
   input  wire        rst_n,
   input  wire        ov_fault,
   input  wire        action_sel,
   input  wire [2:0]  retry_setting,
   input  wire        fault_clear,
   input  wire        run_cmd,
   input  wire [15:0] rise_cycles,
   output reg         out_enable,
   output reg         soft_start
);
   localparam ST_RUN  = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_LAT  = 2'h2;
   reg [1:0]  state_q;
   reg [18:0] cnt_q;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q    <= ST_RUN;
         cnt_q      <= 19'h00000;
         out_enable <= 1'b0;
         soft_start <= 1'b0;
      end
      else
      begin
         soft_start <= 1'b0;
         case (state_q)
            ST_RUN:
            begin
               out_enable <= run_cmd;
               if (ov_fault && action_sel && run_cmd)
               begin
                  out_enable <= 1'b0;
                  if (retry_setting == 3'h0)
                     state_q <= ST_LAT;
                  else
                  begin
                     state_q <= ST_WAIT;
                     cnt_q   <= 19'h00000;
                  end
               end
            end
            ST_WAIT:
            begin
               // restart after seven rise times, no limit
               if (!run_cmd)
                  state_q <= ST_RUN;
               else if (cnt_q >= ({3'h0, rise_cycles} * 19'h7))
               begin
                  state_q    <= ST_RUN;
                  out_enable <= 1'b1;
                  soft_start <= 1'b1;
               end
               else
                  cnt_q <= cnt_q + 19'h00001;
            end
            ST_LAT:
            begin
               if (fault_clear || !run_cmd)
                  state_q <= ST_RUN;
            end
            default:
               state_q <= ST_RUN;
         endcase
      end
   end
endmodule

// ===== vovr_regs_assertions.sv
/* port assertions for the overvoltage register bank.
   assumes a bind onto vovr_regs and one clock. */
`timescale 1ns/1ps
module vovr_chk
(
   input wire        clk,
   input wire        rst_n,
   input wire        wr_en,
   input wire [7:0]  wr_cmd,
   input wire [15:0] wr_data,
   input wire [7:0]  rd_cmd,
   input wire [15:0] rd_data,
   input wire [9:0]  scale_loop,
   input wire        ov_fault_det,
   input wire        ov_warn_det,
   input wire        alert_mask,
   input wire        alert_n,
   input wire [7:0]  status_byte,
   input wire [15:0] status_word,
   input wire [7:0]  status_vout,
   input wire [7:0]  status_cml
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire inval = status_byte[1] & status_cml[6];
   a_retry_reject: assert property (
      wr_en && wr_cmd == 8'h41 && !(&wr_data[5:3] || ~|wr_data[5:3])
      |=> inval) else $error("odd retry accepted");
   a_fault_high: assert property (
      wr_en && wr_cmd == 8'h40 && wr_data[11:0] * scale_loop >= 922
      |=> inval) else $error("high fault limit accepted");
   a_warn_low: assert property (
      wr_en && wr_cmd == 8'h42 && wr_data[11:0] * scale_loop <= 269
      |=> inval) else $error("low warn limit accepted");
   a_fault_flags: assert property (
      ov_fault_det |=> status_byte[5] && status_word[15] && status_vout[7])
      else $error("fault flags missing");
   a_warn_flags: assert property (
      ov_warn_det |=> status_byte[0] && status_word[15] && status_vout[6])
      else $error("warn flags missing");
   a_alert_low: assert property (
      !alert_mask && (inval || status_vout[7]) |-> !alert_n)
      else $error("alert not driven");
   a_resp_fixed: assert property (
      $past(rd_cmd) == 8'h41 |-> !rd_data[6] && rd_data[2:0] == 3'h7)
      else $error("response fixed bits wrong");
   a_cal_exp: assert property (
      $past(rd_cmd) == 8'h39 |-> rd_data[15:11] == 5'h1C
         && rd_data[10:6] inside {5'h00, 5'h1F})
      else $error("offset exponent or sign wrong");
endmodule
bind vovr_regs vovr_chk u_chk (.clk(clk), .rst_n(rst_n), .wr_en(wr_en),
   .wr_cmd(wr_cmd), .wr_data(wr_data), .rd_cmd(rd_cmd), .rd_data(rd_data),
   .scale_loop(scale_loop), .ov_fault_det(ov_fault_det),
   .ov_warn_det(ov_warn_det), .alert_mask(alert_mask), .alert_n(alert_n),
   .status_byte(status_byte), .status_word(status_word),
   .status_vout(status_vout), .status_cml(status_cml));

// ===== vovr_host.sv
/* host model issuing command writes and reads.
   assumes the bank samples strobes on posedge clk. */
`timescale 1ns/1ps
module vovr_host
(
   input  wire         clk,
   input  wire  [15:0] rd_data,
   output logic        wr_en,
   output logic [7:0]  wr_cmd,
   output logic [15:0] wr_data,
   output logic [7:0]  rd_cmd
);
   initial
   begin
      {wr_en, wr_cmd, wr_data, rd_cmd} = 33'h0;
   end
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(negedge clk);
      {wr_en, wr_cmd, wr_data} = {1'b1, c, d};
      @(negedge clk);
      wr_en = 1'b0;
      // stale data inverted so nothing leans on it
      wr_data = ~d;
   endtask
   task automatic rd(input logic [7:0] c, output logic [15:0] d);
      @(negedge clk);
      rd_cmd = c;
      @(negedge clk);
      d = rd_data;
   endtask
endmodule

// ===== vovr_regs_tb.sv
/* self-checking bench for the overvoltage register bank.
   assumes vovr_regs with a short rise time and the host model. */
`timescale 1ns/1ps
module vovr_regs_tb;
   localparam int RLD = 0, STO = 1, CLR = 2, WRN = 3, FLT = 4;
   logic        clk, rst_n, fdet, wdet, clr, sto, rld, mask, run;
   logic        alert_n, oen, ss, wr_en;
   logic [9:0]  scale;
   logic [11:0] vcmd, nfault, nwarn;
   logic [6:0]  ncal;
   logic [7:0]  sb, sv, sc, nresp, wr_cmd, rd_cmd;
   logic [15:0] sw, rdv, wr_data, rd_data;
   int          num_errors, num_checks, n;
   vovr_regs #(.RISE_CYCLES(4)) dut (.clk(clk), .rst_n(rst_n), .wr_en(wr_en),
      .wr_cmd(wr_cmd), .wr_data(wr_data), .rd_cmd(rd_cmd), .rd_data(rd_data),
      .scale_loop(scale), .vout_command(vcmd), .ov_fault_det(fdet),
      .ov_warn_det(wdet), .clear_faults(clr), .store_all(sto),
      .restore_all(rld), .alert_mask(mask), .run_cmd(run),
      .alert_n(alert_n), .status_byte(sb), .status_word(sw),
      .status_vout(sv), .status_cml(sc), .out_enable(oen), .soft_start(ss),
      .nv_fault(nfault), .nv_resp(nresp), .nv_warn(nwarn), .nv_cal(ncal));
   vovr_host u_host (.clk(clk), .rd_data(rd_data), .wr_en(wr_en),
      .wr_cmd(wr_cmd), .wr_data(wr_data), .rd_cmd(rd_cmd));
   task automatic chk(input logic [15:0] g, e);
      num_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [7:0] c, input logic [15:0] e);
      u_host.rd(c, rdv);
      chk(rdv, e);
   endtask
   task automatic pulse(input int k);
      @(negedge clk);
      {fdet, wdet, clr, sto, rld} = 5'h01 << k;
      @(negedge clk);
      {fdet, wdet, clr, sto, rld} = 5'h00;
   endtask
   task automatic count_ss(input int cyc);
      n = 0;
      repeat (cyc) @(negedge clk) if (ss === 1'b1) n++;
   endtask
   task automatic results;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // run needs under 2000 cycles, so this leaves wide margin
   initial
   begin
      #400000;
      num_errors++;
      results();
   end
   initial
   begin
      {rst_n, fdet, wdet, clr, sto, rld, mask} = 7'h00;
      {run, scale, vcmd} = {1'b1, 10'h001, 12'h100};
      {num_errors, num_checks} = 0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      chk({sb, sv}, 16'h0000);
      rchk(8'h40, 16'h0290);
      rchk(8'h42, 16'h0267);
      rchk(8'h41, 16'h00BF);
      rchk(8'h39, 16'hE000);
      u_host.wr(8'h40, 16'h12A0);
      rchk(8'h40, 16'h0290);
      chk({sb[1], sc[6], alert_n, 13'h0}, 16'hC000);
      u_host.wr(8'h40, 16'h0260);
      rchk(8'h40, 16'h0290);
      u_host.wr(8'h40, 16'h039A);
      rchk(8'h40, 16'h0290);
      u_host.wr(8'h40, 16'h0399);
      rchk(8'h40, 16'h0399);
      u_host.wr(8'h42, 16'h010D);
      rchk(8'h42, 16'h0267);
      u_host.wr(8'h42, 16'h010E);
      rchk(8'h42, 16'h010E);
      scale = 10'h002;
      u_host.wr(8'h42, 16'h0086);
      rchk(8'h42, 16'h010E);
      u_host.wr(8'h42, 16'h0087);
      rchk(8'h42, 16'h0087);
      u_host.wr(8'h40, 16'h01CD);
      rchk(8'h40, 16'h0399);
      u_host.wr(8'h40, 16'h01CC);
      rchk(8'h40, 16'h01CC);
      scale = 10'h001;
      u_host.wr(8'h42, 16'h010E);
      for (int r = 0; r < 8; r++)
      begin
         pulse(CLR);
         u_host.wr(8'h41, {10'h002, r[2:0], 3'h7});
         chk({15'h0, sc[6]}, (r == 0 || r == 7) ? 16'h0 : 16'h1);
      end
      rchk(8'h41, 16'h00BF);
      u_host.wr(8'h39, 16'h043F);
      rchk(8'h39, 16'hE7FF);
      $display("test registers done");
      u_host.wr(8'h40, 16'h02AF);
      pulse(STO);
      chk({4'h0, nfault}, 16'h02A0);
      chk({8'h00, nresp}, 16'h00A7);
      chk({4'h0, nwarn}, 16'h010E);
      chk({9'h000, ncal}, 16'h007F);
      pulse(RLD);
      rchk(8'h40, 16'h02A0);
      rchk(8'h42, 16'h0276);
      vcmd = 12'h300;
      pulse(RLD);
      rchk(8'h42, 16'h029F);
      rchk(8'h41, 16'h00BF);
      vcmd = 12'h100;
      $display("test store done");
      pulse(CLR);
      repeat (60) @(negedge clk);
      pulse(FLT);
      chk({sb[5], sw[15], sv[7], alert_n, sb[6], 11'h0}, 16'hE800);
      @(negedge clk);
      chk({15'h0, oen}, 16'h0);
      count_ss(26);
      chk({oen, n[14:0]}, 16'h0);
      count_ss(14);
      chk({oen, n[14:0]}, 16'h8001);
      pulse(FLT);
      count_ss(40);
      chk({oen, n[14:0]}, 16'h8001);
      pulse(FLT);
      run = 1'b0;
      count_ss(10);
      chk({oen, n[14:0]}, 16'h0);
      run = 1'b1;
      pulse(CLR);
      u_host.wr(8'h41, 16'h003F);
      pulse(FLT);
      count_ss(20);
      chk({sv[7], oen, alert_n, n[12:0]}, 16'hC000);
      mask = 1'b1;
      @(negedge clk);
      chk({15'h0, alert_n}, 16'h1);
      mask = 1'b0;
      u_host.wr(8'h41, 16'h0087);
      pulse(CLR);
      pulse(FLT);
      count_ss(60);
      chk({oen, n[14:0]}, 16'h0);
      pulse(CLR);
      @(negedge clk);
      chk({15'h0, oen}, 16'h1);
      pulse(WRN);
      chk({sb[0], sw[15], sv[6], 13'h0}, 16'hE000);
      $display("test faults done");
      results();
   end
endmodule
